// ==== logic/aux_io.sv ====
// Aux digital I/O, function strobe and sync front end with register port
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module aux_io #(
  parameter int unsigned MS_CYCLES = aux_io_pkg::MS_CYCLES_DEF
) (
  // Clock and reset
  input  wire  logic                          clock,
  input  wire  logic                          rst,
  // Register port
  input  wire  logic [aux_io_pkg::ADDR_W-1:0] addr,
  input  wire  logic [aux_io_pkg::DATA_W-1:0] wdata,
  input  wire  logic                          wr,
  input  wire  logic                          rd,
  output logic [aux_io_pkg::DATA_W-1:0]       rdata,
  // Digital inputs and actions
  input  wire  logic [aux_io_pkg::N_DIN-1:0]  din,
  output logic                                action_valid,
  output logic [aux_io_pkg::ACT_W-1:0]        action_code,
  // Status sources
  input  wire  logic                          output_enabled,
  input  wire  logic                          single_phase,
  input  wire  logic                          fault,
  input  wire  logic                          transient_active,
  input  wire  logic                          program_active,
  input  wire  logic                          remote_state,
  // Digital outputs and remote bits
  output logic [aux_io_pkg::N_DOUT-1:0]       dout,
  output logic                                remote_enable,
  output logic                                remote_inhibit,
  // Function strobe
  input  wire  logic                          relay_state,
  input  wire  logic                          program_changed,
  input  wire  logic                          transient_start,
  output logic                                function_strobe,
  // Sync front end
  input  wire  logic                          ttl_sync,
  input  wire  logic                          line_sync,
  input  wire  logic [aux_io_pkg::FREQ_W-1:0] pll_freq_req,
  input  wire  logic                          pll_locked,
  output logic                                sync_enable,
  output logic                                sync_ref_edge,
  output logic [aux_io_pkg::FREQ_W-1:0]       sync_phase_offset,
  output logic [aux_io_pkg::FREQ_W-1:0]       sync_speed,
  output logic [aux_io_pkg::FREQ_W-1:0]       freq_cmd,
  output logic                                sync_locked
);
  import aux_io_pkg::*;

  // sts LSB first: enable up to remote
  function automatic logic src_level(input dout_src_t sel,
                                     input logic [5:0] sts);
    unique case (sel)
      SRC_LOW:    src_level = 1'b0;
      SRC_HIGH:   src_level = 1'b1;
      SRC_OUT_EN: src_level = sts[0];
      SRC_PHASE:  src_level = sts[1];
      SRC_FAULT:  src_level = sts[2];
      SRC_TRANS:  src_level = sts[3];
      SRC_PROG:   src_level = sts[4];
      SRC_REMOTE: src_level = sts[5];
    endcase
  endfunction : src_level

  // Word k of a register group
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] base,
                               input int unsigned k);
    hit = a == base + ADDR_W'(k) * WORD_STEP;
  endfunction : hit

  logic [N_DIN-1:0]     lvl;
  logic [N_DIN-1:0]     rise;
  logic [N_DIN-1:0]     fall;
  logic [FILT_W-1:0]    filter_r [N_DIN];
  logic [ACT_W-1:0]     rise_act_r [N_DIN];
  logic [ACT_W-1:0]     fall_act_r [N_DIN];
  dout_src_t            dsrc_r [N_DOUT];
  logic [N_DOUT-1:0]    dinv_r;
  logic [N_DOUT-1:0]    dout_r;
  logic [DIN_IDX_W-1:0] din_idx_r;
  logic                 rem_en_r;
  logic                 rem_inh_r;
  logic [2:0]           stb_mode_r;
  logic                 sync_en_r;
  logic                 sync_ttl_r;
  logic [FREQ_W-1:0]    phase_r;
  logic [FREQ_W-1:0]    setpoint_r;
  logic [FREQ_W-1:0]    window_r;
  logic [FREQ_W-1:0]    speed_r;
  logic [FREQ_W-1:0]    freq_r;
  logic                 locked_r;
  logic [N_EVT-1:0]     pend_r;
  logic [N_EVT-1:0]     pend_nxt;
  logic [N_EVT-1:0]     serve;
  logic                 act_valid_r;
  logic [ACT_W-1:0]     act_code_r;
  logic [ACT_W-1:0]     act_nxt;
  logic                 relay_d_r;
  logic                 strobe_r;
  logic [1:0]           ref_meta_r;
  logic [1:0]           ref_sync_r;
  logic                 ref_d_r;
  logic                 ref_edge_r;
  logic [DATA_W-1:0]    rdata_r;
  logic [DATA_W-1:0]    rdata_nxt;
  logic [5:0]           sts;
  logic [FREQ_W:0]      lo;
  logic [FREQ_W:0]      hi;
  logic [FREQ_W-1:0]    wval;

  assign wval = wdata[FREQ_W-1:0];
  assign sts = {remote_state, program_active, transient_active,
                fault, single_phase, output_enabled};

  // Input channels
  for (genvar i = 0; i < N_DIN; i++) begin : g_din
    din_filter #(.MS_CYCLES(MS_CYCLES)) u_filt (
      .clock     (clock),
      .rst       (rst),
      .pin       (din[i]),
      .filter_ms (filter_r[i]),
      .level     (lvl[i]),
      .rise      (rise[i]),
      .fall      (fall[i])
    );
    always_ff @(posedge clock) begin
      if (rst) begin
        filter_r[i]   <= '0;
        rise_act_r[i] <= '0;
        fall_act_r[i] <= '0;
      end else if (wr && hit(addr, OFF_FILTER0, i)) begin
        // Full word compared, so big values cannot wrap
        filter_r[i] <= (wdata > DATA_W'(FILTER_MAX_MS)) ?
                       FILTER_MAX_MS : wdata[FILT_W-1:0];
      end else if (wr && hit(addr, OFF_ACTION0, i)) begin
        rise_act_r[i] <= wdata[ACT_W-1:0];
        fall_act_r[i] <= wdata[ACT_FALL_LSB +: ACT_W];
      end
    end
  end

  // One action per cycle; events that collide wait in the pending set
  always_comb begin
    serve   = '0;
    act_nxt = '0;
    for (int k = N_EVT - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        serve = N_EVT'(1) << k;
        act_nxt = (k < N_DIN) ? rise_act_r[k % N_DIN]
                              : fall_act_r[k % N_DIN];
      end
    end
    pend_nxt = (pend_r & ~serve) | {fall, rise};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pend_r      <= '0;
      act_valid_r <= 1'b0;
      act_code_r  <= '0;
    end else begin
      pend_r      <= pend_nxt;
      act_valid_r <= |serve;
      // Code holds until the next action
      if (|serve) begin
        act_code_r <= act_nxt;
      end
    end
  end

  // Digital outputs
  for (genvar j = 0; j < N_DOUT; j++) begin : g_dout
    always_ff @(posedge clock) begin
      if (rst) begin
        dsrc_r[j] <= (j == 0) ? DOUT0_RST : DOUT1_RST;
        dinv_r[j] <= 1'b0;
        dout_r[j] <= 1'b0;
      end else begin
        if (wr && hit(addr, OFF_DOUT0, j)) begin
          dsrc_r[j] <= dout_src_t'(wdata[2:0]);
          dinv_r[j] <= wdata[INV_BIT];
        end
        // Registered: no glitch on a source switch
        dout_r[j] <= src_level(dsrc_r[j], sts) ^ dinv_r[j];
      end
    end
  end

  // Control bits
  always_ff @(posedge clock) begin
    if (rst) begin
      din_idx_r  <= '0;
      rem_en_r   <= 1'b0;
      rem_inh_r  <= 1'b0;
      stb_mode_r <= '0;
      sync_en_r  <= 1'b0;
      sync_ttl_r <= 1'b0;
      phase_r    <= '0;
      setpoint_r <= SETPOINT_RST;
      window_r   <= WINDOW_RST;
      speed_r    <= SPEED_MIN;
    end else if (wr) begin
      unique case (addr)
        OFF_DIN:      din_idx_r <= wdata[DIN_IDX_W-1:0];
        OFF_REMOTE: begin
          rem_en_r  <= wdata[BIT_REM_EN];
          rem_inh_r <= wdata[BIT_REM_INH];
        end
        OFF_STROBE:   stb_mode_r <= wdata[2:0];
        OFF_SYNC: begin
          sync_en_r  <= wdata[BIT_SYNC_EN];
          sync_ttl_r <= wdata[BIT_SYNC_TTL];
        end
        OFF_PHASE:    phase_r <= wval;
        OFF_SETPOINT: setpoint_r <= wval;
        OFF_WINDOW:   window_r <= wval;
        OFF_SPEED: begin
          // Clamped, not refused
          speed_r <= (wval < SPEED_MIN) ? SPEED_MIN :
                     (wval > SPEED_MAX) ? SPEED_MAX : wval;
        end
        default: ;
      endcase
    end
  end

  // Function strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      relay_d_r <= 1'b0;
      strobe_r  <= 1'b0;
    end else begin
      // Relay is a level; the others are pulses
      relay_d_r <= relay_state;
      strobe_r <= (stb_mode_r[BIT_STB_RLY] &
                   (relay_state ^ relay_d_r)) |
                  (stb_mode_r[BIT_STB_PRG] & program_changed) |
                  (stb_mode_r[BIT_STB_TRN] & transient_start);
    end
  end

  // Sync reference: both pins synchronised, selected one edge-detected
  always_ff @(posedge clock) begin
    ref_meta_r <= {ttl_sync, line_sync};
    ref_sync_r <= ref_meta_r;
  end

  // Bounds carry a borrow or carry bit on top
  assign lo = {1'b0, setpoint_r} - {1'b0, window_r};
  assign hi = {1'b0, setpoint_r} + {1'b0, window_r};

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_d_r    <= 1'b0;
      ref_edge_r <= 1'b0;
      freq_r     <= SETPOINT_RST;
      locked_r   <= 1'b0;
    end else begin
      ref_d_r    <= sync_ttl_r ? ref_sync_r[1] : ref_sync_r[0];
      ref_edge_r <= sync_en_r & ~ref_d_r &
                    (sync_ttl_r ? ref_sync_r[1] : ref_sync_r[0]);
      locked_r   <= sync_en_r & pll_locked;
      // A wrapped bound is left off
      if (!sync_en_r) begin
        freq_r <= setpoint_r;
      end else if (!lo[FREQ_W] && pll_freq_req < lo[FREQ_W-1:0]) begin
        freq_r <= lo[FREQ_W-1:0];
      end else if (!hi[FREQ_W] && pll_freq_req > hi[FREQ_W-1:0]) begin
        freq_r <= hi[FREQ_W-1:0];
      end else begin
        freq_r <= pll_freq_req;
      end
    end
  end

  // Register reads
  // Unmapped addresses and unused bits read zero
  always_comb begin
    rdata_nxt = '0;
    for (int i = 0; i < N_DIN; i++) begin
      if (hit(addr, OFF_FILTER0, i)) begin
        rdata_nxt[FILT_W-1:0] = filter_r[i];
      end
      if (hit(addr, OFF_ACTION0, i)) begin
        rdata_nxt[ACT_W-1:0] = rise_act_r[i];
        rdata_nxt[ACT_FALL_LSB +: ACT_W] = fall_act_r[i];
      end
    end
    for (int j = 0; j < N_DOUT; j++) begin
      if (hit(addr, OFF_DOUT0, j)) begin
        rdata_nxt[2:0] = dsrc_r[j];
        rdata_nxt[INV_BIT] = dinv_r[j];
      end
    end
    unique case (addr)
      OFF_DIN:
        // Index zero returns all levels
        if (din_idx_r == '0) begin
          rdata_nxt[N_DIN-1:0] = lvl;
        end else begin
          rdata_nxt[0] = lvl[din_idx_r - 1'b1];
        end
      OFF_DOUT_LVL: rdata_nxt[N_DOUT-1:0] = dout_r;
      OFF_REMOTE:   rdata_nxt[1:0] = {rem_inh_r, rem_en_r};
      OFF_STROBE:   rdata_nxt[2:0] = stb_mode_r;
      OFF_SYNC:     rdata_nxt[1:0] = {sync_ttl_r, sync_en_r};
      OFF_PHASE:    rdata_nxt[FREQ_W-1:0] = phase_r;
      OFF_SETPOINT: rdata_nxt[FREQ_W-1:0] = setpoint_r;
      OFF_WINDOW:   rdata_nxt[FREQ_W-1:0] = window_r;
      OFF_SPEED:    rdata_nxt[FREQ_W-1:0] = speed_r;
      OFF_SYNC_STS: begin
        rdata_nxt[0] = locked_r;
        rdata_nxt[STS_FREQ_LSB +: FREQ_W] = freq_r;
      end
      default: ;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd ? rdata_nxt : '0;
    end
  end

  assign rdata             = rdata_r;
  assign action_valid      = act_valid_r;
  assign action_code       = act_code_r;
  assign dout              = dout_r;
  assign remote_enable     = rem_en_r;
  assign remote_inhibit    = rem_inh_r;
  assign function_strobe   = strobe_r;
  assign sync_enable       = sync_en_r;
  assign sync_ref_edge     = ref_edge_r;
  assign sync_phase_offset = phase_r;
  assign sync_speed        = speed_r;
  assign freq_cmd          = freq_r;
  assign sync_locked       = locked_r;
endmodule : aux_io
`default_nettype wire

// ==== logic/din_filter.sv ====
// One digital input: synchroniser, hold-time filter and edge events
`timescale 1ns/10ps
`default_nettype none
module din_filter #(
  parameter int unsigned MS_CYCLES = aux_io_pkg::MS_CYCLES_DEF
) (
  // Clock and reset
  input  wire  logic                        clock,
  input  wire  logic                        rst,
  // Pin and setting
  input  wire  logic                        pin,
  input  wire  logic [aux_io_pkg::FILT_W-1:0] filter_ms,
  // Qualified level and events
  output logic                              level,
  output logic                              rise,
  output logic                              fall
);
  import aux_io_pkg::*;
  localparam logic [MS_CNT_W-1:0] SUB_LAST = MS_CNT_W'(MS_CYCLES - 1);
  logic                meta_r;
  logic                sync_r;
  logic                level_r;
  logic                rise_r;
  logic                fall_r;
  logic [MS_CNT_W-1:0] sub_r;
  logic [FILT_W-1:0]   ms_r;
  logic                differ;
  logic                ms_done;
  logic                qualify;

  always_ff @(posedge clock) begin
    meta_r <= pin;
    sync_r <= meta_r;
  end

  assign differ  = sync_r != level_r;
  assign ms_done = sub_r == SUB_LAST;
  // Lowering the filter mid-count must not strand the edge, hence >=
  assign qualify = differ && ((filter_ms == '0) ||
                   (ms_done && ms_r >= filter_ms - 1'b1));

  // Timer restarts whenever the level falls back, so holds are continuous
  always_ff @(posedge clock) begin
    if (rst || !differ) begin
      sub_r <= '0;
      ms_r  <= '0;
    end else if (ms_done) begin
      sub_r <= '0;
      ms_r  <= ms_r + 1'b1;
    end else begin
      sub_r <= sub_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      level_r <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      if (qualify) begin
        level_r <= sync_r;
      end
      rise_r <= qualify & sync_r;
      fall_r <= qualify & ~sync_r;
    end
  end

  assign level = level_r;
  assign rise  = rise_r;
  assign fall  = fall_r;
endmodule : din_filter
`default_nettype wire

// ==== shared/aux_io_pkg.sv ====
// Constants, register map and field positions for the aux digital I/O block
package aux_io_pkg;
  localparam int unsigned N_DIN        = 3;
  localparam int unsigned N_DOUT       = 2;
  localparam int unsigned N_EVT        = 2 * N_DIN;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned FILT_W       = 10;
  localparam int unsigned MS_CNT_W     = 15;
  localparam int unsigned ACT_W        = 8;
  localparam int unsigned FREQ_W       = 16;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam logic [FILT_W-1:0] FILTER_MAX_MS = 10'h3e8;
  localparam logic [FREQ_W-1:0] SPEED_MIN     = 16'h03e8;
  localparam logic [FREQ_W-1:0] SPEED_MAX     = 16'h2710;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFF_DIN      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FILTER0  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACTION0  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DOUT0    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_DOUT_LVL = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_REMOTE   = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_STROBE   = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_SYNC     = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_PHASE    = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_SETPOINT = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_WINDOW   = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_SPEED    = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_SYNC_STS = 8'h44;
  localparam logic [ADDR_W-1:0] WORD_STEP    = 8'h04;
  // Field positions
  localparam int unsigned DIN_IDX_W    = 2;
  localparam int unsigned ACT_FALL_LSB = 8;
  localparam int unsigned INV_BIT      = 4;
  localparam int unsigned BIT_REM_EN   = 0;
  localparam int unsigned BIT_REM_INH  = 1;
  localparam int unsigned BIT_STB_RLY  = 0;
  localparam int unsigned BIT_STB_PRG  = 1;
  localparam int unsigned BIT_STB_TRN  = 2;
  localparam int unsigned BIT_SYNC_EN  = 0;
  localparam int unsigned BIT_SYNC_TTL = 1;
  localparam int unsigned STS_FREQ_LSB = 16;
  typedef enum logic [2:0] {
    SRC_LOW, SRC_HIGH, SRC_OUT_EN, SRC_PHASE,
    SRC_FAULT, SRC_TRANS, SRC_PROG, SRC_REMOTE
  } dout_src_t;
  localparam dout_src_t DOUT0_RST = SRC_OUT_EN;
  localparam dout_src_t DOUT1_RST = SRC_PHASE;
  localparam logic [FREQ_W-1:0] SETPOINT_RST = 16'h1770;
  localparam logic [FREQ_W-1:0] WINDOW_RST   = 16'h03e8;
endpackage : aux_io_pkg

// ==== tb/aux_io_chk.sv ====
// Port checker for the aux digital I/O block, bound to every instance
`timescale 1ns/10ps
`default_nettype none
module aux_io_chk (
  // Clock and reset
  input wire logic                          clock,
  input wire logic                          rst,
  // Register writes
  input wire logic [aux_io_pkg::ADDR_W-1:0] addr,
  input wire logic [aux_io_pkg::DATA_W-1:0] wdata,
  input wire logic                          wr,
  // Status sources and outputs
  input wire logic                          output_enabled,
  input wire logic                          single_phase,
  input wire logic                          fault,
  input wire logic                          transient_active,
  input wire logic                          program_active,
  input wire logic                          remote_state,
  input wire logic [aux_io_pkg::N_DOUT-1:0] dout,
  input wire logic                          remote_enable,
  input wire logic                          remote_inhibit,
  // Function strobe
  input wire logic                          program_changed,
  input wire logic                          transient_start,
  input wire logic                          function_strobe,
  // Sync front end
  input wire logic                          pll_locked,
  input wire logic                          sync_enable,
  input wire logic [aux_io_pkg::FREQ_W-1:0] freq_cmd,
  input wire logic                          sync_locked
);
  import aux_io_pkg::*;
  logic [4:0]        cfg0_r;
  logic [4:0]        cfg1_r;
  logic [2:0]        stb_r;
  logic [FREQ_W-1:0] setp_r;
  logic [FREQ_W-1:0] win_r;
  logic [7:0]        src;
  assign src = {remote_state, program_active, transient_active, fault,
                single_phase, output_enabled, 2'b10};
  // Shadow of the settings, same one-cycle write latency as the block
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg0_r <= {2'b00, DOUT0_RST};
      cfg1_r <= {2'b00, DOUT1_RST};
      stb_r  <= 3'h0;
      setp_r <= SETPOINT_RST;
      win_r  <= WINDOW_RST;
    end else if (wr) begin
      if (addr == OFF_DOUT0) cfg0_r <= wdata[4:0];
      if (addr == OFF_DOUT0 + WORD_STEP) cfg1_r <= wdata[4:0];
      if (addr == OFF_STROBE) stb_r <= wdata[2:0];
      if (addr == OFF_SETPOINT) setp_r <= wdata[15:0];
      if (addr == OFF_WINDOW) win_r <= wdata[15:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_prog_req;  program_changed && stb_r[BIT_STB_PRG]; endsequence
  sequence s_trans_req; transient_start && stb_r[BIT_STB_TRN]; endsequence
  property p_dout0;
    !$past(rst) |-> dout[0] == $past(src[cfg0_r[2:0]] ^ cfg0_r[INV_BIT]);
  endproperty
  property p_dout1;
    !$past(rst) |-> dout[1] == $past(src[cfg1_r[2:0]] ^ cfg1_r[INV_BIT]);
  endproperty
  property p_remote;
    wr && addr == OFF_REMOTE |=>
      {remote_inhibit, remote_enable} == $past(wdata[1:0]);
  endproperty
  property p_prog_strobe;  s_prog_req |=> function_strobe;  endproperty
  property p_trans_strobe; s_trans_req |=> function_strobe; endproperty
  property p_lock; sync_locked == $past(sync_enable && pll_locked); endproperty
  property p_freq_off;
    !$past(sync_enable) |-> freq_cmd == $past(setp_r);
  endproperty
  // Bounds that wrap past 16 bits fall away in 17-bit arithmetic
  property p_freq_win;
    $past(sync_enable) |-> {1'b0, freq_cmd} + $past(win_r) >= $past(setp_r)
      && {1'b0, freq_cmd} <= $past(setp_r) + $past(win_r);
  endproperty
  a_dout0: assert property (p_dout0)
    else $error("first output differs from its source");
  a_dout1: assert property (p_dout1)
    else $error("second output differs from its source");
  a_remote: assert property (p_remote)
    else $error("remote bits do not follow the write");
  a_prog_strobe: assert property (p_prog_strobe)
    else $error("no strobe on program change");
  a_trans_strobe: assert property (p_trans_strobe)
    else $error("no strobe on transient start");
  a_lock: assert property (p_lock)
    else $error("lock status wrong");
  a_freq_off: assert property (p_freq_off)
    else $error("frequency not at setpoint with sync off");
  a_freq_win: assert property (p_freq_win)
    else $error("frequency outside the sync window");
endmodule : aux_io_chk
bind aux_io aux_io_chk chk (.clock, .rst, .addr, .wdata, .wr,
  .output_enabled, .single_phase, .fault, .transient_active,
  .program_active, .remote_state, .dout, .remote_enable, .remote_inhibit,
  .program_changed, .transient_start, .function_strobe, .pll_locked,
  .sync_enable, .freq_cmd, .sync_locked);
`default_nettype wire

// ==== tb/aux_io_test.sv ====
// Self-checking bench for the aux digital I/O block
`timescale 1ns/10ps
`default_nettype none
module aux_io_test;
  import aux_io_pkg::*;
  localparam int unsigned MSC = 4;
  logic              clock = 1'b0;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [5:0]        sts;
  logic              relay_state;
  logic              program_changed;
  logic              transient_start;
  logic [FREQ_W-1:0] pll_freq_req;
  logic              pll_locked;
  logic [DATA_W-1:0] rdata;
  logic [N_DIN-1:0]  din;
  logic              ttl_sync, line_sync, action_valid, remote_enable;
  logic              remote_inhibit, function_strobe, sync_enable;
  logic              sync_ref_edge, sync_locked;
  logic [ACT_W-1:0]  action_code;
  logic [N_DOUT-1:0] dout;
  logic [FREQ_W-1:0] sync_phase_offset, sync_speed, freq_cmd;
  int                miscompares = 0;
  int                comparisons = 0;
  int                f;
  always #20 clock = ~clock;
  ext_equipment eq (.clock, .din, .ttl_sync, .line_sync);
  aux_io #(.MS_CYCLES(MSC)) uut (.clock, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .din, .action_valid, .action_code, .output_enabled(sts[0]),
    .single_phase(sts[1]), .fault(sts[2]), .transient_active(sts[3]),
    .program_active(sts[4]), .remote_state(sts[5]), .dout, .remote_enable,
    .remote_inhibit, .relay_state, .program_changed, .transient_start,
    .function_strobe, .ttl_sync, .line_sync, .pll_freq_req, .pll_locked,
    .sync_enable, .sync_ref_edge, .sync_phase_offset, .sync_speed,
    .freq_cmd, .sync_locked);
  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rd_chk
  // Counts pulses of one output over a bounded window
  task automatic watch(input int s, len, exp, output int first);
    int   hits;
    logic v;
    hits  = 0;
    first = -1;
    for (int i = 0; i < len; i++) begin
      #1 v = s == 0 ? action_valid : s == 1 ? function_strobe : sync_ref_edge;
      if (v === 1'b1) begin
        if (first < 0) first = i;
        hits++;
      end
      @(posedge clock);
    end
    chk("pulse count", exp, hits);
    if (exp > 0 && hits == 0) print_verdict();
  endtask : watch
  task automatic pulse(input int s);
    @(posedge clock);
    if (s == 0) relay_state <= ~relay_state;
    else if (s == 1) program_changed <= 1'b1;
    else transient_start <= 1'b1;
    @(posedge clock);
    program_changed <= 1'b0;
    transient_start <= 1'b0;
  endtask : pulse
  task automatic t_reset();
    repeat (2) @(posedge clock);
    #1 chk("dout", 32'h3, 32'(dout));
    rd_chk(OFF_SETPOINT, 32'h1770);
    rd_chk(OFF_SPEED, 32'h03e8);
    rd_chk(8'hfc, 32'h0);
  endtask : t_reset
  task automatic t_dout();
    logic [7:0] src;
    logic [5:0] pat;
    logic [3:0] c;
    for (int p = 0; p < 2; p++) begin
      pat = p ? 6'h16 : 6'h29;
      @(posedge clock);
      sts <= pat;
      for (int k = 0; k < 16; k++) begin
        c   = 4'(k);
        src = {pat, 2'b10};
        wr_reg(OFF_DOUT0, 32'({c[3], 1'b0, c[2:0]}));
        wr_reg(OFF_DOUT0 + WORD_STEP, 32'({c[3], 1'b0, c[2:0]}));
        repeat (2) @(posedge clock);
        #1 chk("dout", {30'h0, {2{src[c[2:0]] ^ c[3]}}}, 32'(dout));
      end
    end
  endtask : t_dout
  task automatic t_din();
    wr_reg(OFF_ACTION0, 32'h2211);
    wr_reg(OFF_ACTION0 + WORD_STEP, 32'h0033);
    wr_reg(OFF_FILTER0, 32'd2000);
    rd_chk(OFF_FILTER0, 32'd1000);
    wr_reg(OFF_FILTER0, 32'd2);
    // Short glitch must leave no trace
    eq.set_din(3'b001);
    repeat (2) @(posedge clock);
    eq.set_din(3'b000);
    watch(0, 24, 0, f);
    eq.set_din(3'b001);
    watch(0, 24, 1, f);
    chk("hold time", 1, 32'(f >= 2 * MSC && f <= 4 * MSC + 6));
    chk("action code", 32'h11, 32'(action_code));
    wr_reg(OFF_FILTER0, 32'd0);
    eq.set_din(3'b000);
    watch(0, 8, 1, f);
    chk("immediate", 1, 32'(f <= 5));
    chk("action code", 32'h22, 32'(action_code));
    eq.set_din(3'b110);
    watch(0, 10, 2, f);
    wr_reg(OFF_DIN, 32'd0);
    rd_chk(OFF_DIN, 32'h6);
    for (int n = 1; n <= 3; n++) begin
      wr_reg(OFF_DIN, 32'(n));
      rd_chk(OFF_DIN, 32'(n > 1));
    end
  endtask : t_din
  task automatic t_strobe();
    for (int m = 0; m < 3; m++) begin
      wr_reg(OFF_STROBE, 32'(1 << m));
      for (int s = 0; s < 3; s++) begin
        pulse(s);
        watch(1, 4, int'(s == m), f);
      end
    end
  endtask : t_strobe
  task automatic t_sync();
    @(posedge clock);
    pll_locked   <= 1'b1;
    pll_freq_req <= 16'h2000;
    wr_reg(OFF_WINDOW, 32'h64);
    wr_reg(OFF_SYNC, 32'h3);
    repeat (2) @(posedge clock);
    #1 chk("freq", 32'h17d4, 32'(freq_cmd));
    rd_chk(OFF_SYNC_STS, 32'h17d40001);
    eq.set_sync(2'b01);
    watch(2, 8, 1, f);
    eq.set_sync(2'b00);
    wr_reg(OFF_SYNC, 32'h1);
    eq.set_sync(2'b01);
    watch(2, 8, 0, f);
    eq.set_sync(2'b11);
    watch(2, 8, 1, f);
    pll_freq_req <= 16'h1000;
    repeat (2) @(posedge clock);
    #1 chk("freq", 32'h170c, 32'(freq_cmd));
    wr_reg(OFF_SYNC, 32'h0);
    eq.set_sync(2'b00);
    eq.set_sync(2'b11);
    watch(2, 8, 0, f);
    chk("lock", 32'h0, 32'(sync_locked));
    wr_reg(OFF_PHASE, 32'h0123);
    repeat (2) @(posedge clock);
    #1 chk("phase", 32'h0123, 32'(sync_phase_offset));
    wr_reg(OFF_SPEED, 32'h2);
    rd_chk(OFF_SPEED, 32'h03e8);
    wr_reg(OFF_SPEED, 32'h2710);
    rd_chk(OFF_SPEED, 32'h2710);
    chk("speed", 32'h2710, 32'(sync_speed));
  endtask : t_sync
  initial begin
    rst <= 1'b1;
    sts <= 6'h03;
    {addr, wdata, wr, rd, relay_state, program_changed} <= '0;
    {transient_start, pll_freq_req, pll_locked} <= '0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_dout();
    t_din();
    wr_reg(OFF_REMOTE, 32'h3);
    rd_chk(OFF_REMOTE, 32'h3);
    chk("remote", 32'h3, 32'({remote_inhibit, remote_enable}));
    t_strobe();
    t_sync();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
endmodule : aux_io_test
`default_nettype wire

// ==== tb/ext_equipment.sv ====
// Test equipment model on the digital input and sync lines
`timescale 1ns/10ps
`default_nettype none
module ext_equipment (
  // Timing reference
  input  wire logic                         clock,
  // Lines into the block
  output var  logic [aux_io_pkg::N_DIN-1:0] din,
  output var  logic                         ttl_sync,
  output var  logic                         line_sync
);
  initial begin
    din       = '0;
    ttl_sync  = 1'b0;
    line_sync = 1'b0;
  end
  task automatic set_din(input logic [aux_io_pkg::N_DIN-1:0] v);
    @(posedge clock);
    din <= v;
  endtask : set_din
  // Bit 0 is the TTL line, bit 1 the line reference
  task automatic set_sync(input logic [1:0] v);
    @(posedge clock);
    {line_sync, ttl_sync} <= v;
  endtask : set_sync
endmodule : ext_equipment
`default_nettype wire
